// ### hw/fdcc_commit_reg.sv
// register that takes a staged value only on a commit strobe
`timescale 1ns/1ps

module fdcc_commit_reg #(
    parameter int           W         = 8,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    input  wire logic         load,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q,
    output logic              applied
);

    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;
    logic         applied_reg;
    logic         applied_next;

    always_comb begin
        q_next       = load ? d : q_reg;
        applied_next = load;
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            q_reg       <= RESET_VAL;
            applied_reg <= 1'b0;
        end else begin
            q_reg       <= q_next;
            applied_reg <= applied_next;
        end
    end

    assign q       = q_reg;
    assign applied = applied_reg;

endmodule

// ### hw/fdcc_phase_seq.sv
// phase adjust sequencer: immediate request and post-sync application
`timescale 1ns/1ps

module fdcc_phase_seq (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic adjust_request,
    input  wire logic post_sync_enable,
    input  wire logic sync_event,
    input  wire logic adjust_done,
    output logic      busy,
    output logic      apply
);

    fdcc_pkg::fdcc_seq_state_t state_reg;
    fdcc_pkg::fdcc_seq_state_t state_next;

    // ****************************************************************
    // state machine
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            fdcc_pkg::FDCC_SEQ_IDLE: begin
                if (adjust_request) begin
                    state_next = fdcc_pkg::FDCC_SEQ_REQ;
                end
            end
            fdcc_pkg::FDCC_SEQ_REQ: begin
                state_next = fdcc_pkg::FDCC_SEQ_WAIT;
            end
            fdcc_pkg::FDCC_SEQ_WAIT: begin
                if (adjust_done) begin
                    state_next = fdcc_pkg::FDCC_SEQ_IDLE;
                end
            end
            default: begin
                state_next = fdcc_pkg::FDCC_SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_reg <= fdcc_pkg::FDCC_SEQ_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign busy  = (state_reg != fdcc_pkg::FDCC_SEQ_IDLE);
    // post-sync application on every sync while enabled
    assign apply = (state_reg == fdcc_pkg::FDCC_SEQ_REQ)
                 | (sync_event & post_sync_enable);

    // ****************************************************************
    // checks
    // ****************************************************************
    imm_apply_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (adjust_request && !busy) |=> apply ##1 busy)
        else $error("immediate adjust not applied");

    self_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (busy && adjust_done && state_reg == fdcc_pkg::FDCC_SEQ_WAIT) |=> !busy)
        else $error("adjust bit did not self clear");

    post_sync_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (sync_event && post_sync_enable) |-> apply)
        else $error("post sync adjust missing");

    imm_cover: cover property (@(posedge clk_sys) disable iff (!resetn)
        (adjust_request && !busy) ##[1:20] (busy && adjust_done));

    sync_cover: cover property (@(posedge clk_sys) disable iff (!resetn)
        sync_event && post_sync_enable);

endmodule

// ### hw/fdcc_pkg.sv
// types shared by the fractional divider control modules
package fdcc_pkg;

    // gray coded along idle -> request -> wait
    typedef enum logic [1:0] {
        FDCC_SEQ_IDLE = 2'h0,
        FDCC_SEQ_REQ  = 2'h1,
        FDCC_SEQ_WAIT = 2'h3
    } fdcc_seq_state_t;

endpackage

// ### hw/fdcc_regs.svh
// register offsets, field positions, reset values for the fractional divider control
`ifndef FDCC_REGS_SVH
`define FDCC_REGS_SVH

// ****************************************************************
// byte addresses
// ****************************************************************
`define FDCC_ADDR_W              4
`define FDCC_ADDR_RATIO_LAST     4'h7
`define FDCC_ADDR_PHASE_LO       4'h8
`define FDCC_ADDR_PHASE_HI       4'h9
`define FDCC_ADDR_STATUS         4'hA

// ****************************************************************
// ratio register fields
// ****************************************************************
`define FDCC_RATIO_W             64
`define FDCC_RATIO_PD_BIT        63
`define FDCC_RATIO_DIS_BIT       62
`define FDCC_RATIO_RST_BIT       61
`define FDCC_RATIO_ACC_BIT       60
`define FDCC_FRAC_MSB            59
`define FDCC_FRAC_LSB            26
`define FDCC_FRAC_W              34
`define FDCC_FRAC_DEN_LOG2       34
`define FDCC_SSC_ZERO_W          6
`define FDCC_SECOND_MSB          25
`define FDCC_SECOND_LSB          9
`define FDCC_SECOND_W            17
`define FDCC_FIRST_MSB           8
`define FDCC_FIRST_W             9
`define FDCC_GROUP_W             43
`define FDCC_RATIO_RESET         64'h0000_0000_0000_0064
`define FDCC_FIRST_RESET         9'h064

// ****************************************************************
// phase register fields
// ****************************************************************
`define FDCC_PHASE_REG_W         16
`define FDCC_PH_ADJ_NOW_BIT      15
`define FDCC_PH_POST_SYNC_BIT    14
`define FDCC_PH_SLOW_BIT         13
`define FDCC_PH_RSVD_BIT         12
`define FDCC_PH_GROUP_MSB        11
`define FDCC_PH_GROUP_LSB        10
`define FDCC_PH_MSB              9
`define FDCC_PH_W                10
`define FDCC_PHASE_REG_RESET     16'h43F0
`define FDCC_PHASE_RESET         10'h3F0
`define FDCC_SYNC_GROUP0         2'h0
`define FDCC_SYNC_GROUP1         2'h1

`endif

// ### hw/fdcc_top.sv
// fractional divider configuration and control, register slave and divider controls
//
// Function
// - power-down control high turns the divider regulator off.
// - disable control high disables the fractional divider.
// - divider reset control high holds the divider in reset.
// - accumulator reset control resets the modulator accumulator, independent of divider reset.
// - fraction field is a numerator over a fixed two to the 34th.
// - first-stage integer and fraction apply together on top fraction byte write.
// - second stage divides by twice value, zero bypasses, one is illegal.
// - nine-bit first-stage integer is the ratio, reset value one hundred.
// - zero-to-one write of immediate adjust applies phase, then self-clears.
// - post-sync adjust applies phase on every sync; resets to one.
// - group field 0 and 1 pick groups zero and one, else none.
// - phase is signed quarter-VCO-period count; positive delays, negative advances.
// - phase resets to minus sixteen quarter periods.
// - phase updates as a unit only when its upper byte is written.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "fdcc_regs.svh"

module fdcc_top (
    input  wire logic                         clk_sys,
    input  wire logic                         resetn,
    input  wire logic [`FDCC_ADDR_W-1:0]      reg_addr,
    input  wire logic [7:0]                   reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [7:0]                   reg_rdata,
    input  wire logic                         spread_active,
    input  wire logic                         sync_event,
    input  wire logic                         phase_adjust_done,
    output logic                              divider_power_down,
    output logic                              div_disable,
    output logic                              div_reset,
    output logic                              acc_reset,
    output logic      [`FDCC_FIRST_W-1:0]     first_stage_integer,
    output logic      [`FDCC_FRAC_W-1:0]      frac_numerator,
    output logic                              ratio_apply,
    output logic      [`FDCC_SECOND_W:0]      second_stage_ratio,
    output logic                              second_stage_bypass,
    output logic                              slow_freq_en,
    output logic                              sync_group0_member,
    output logic                              sync_group1_member,
    output logic signed [`FDCC_PH_W-1:0]      phase_offset,
    output logic                              phase_apply
);

    // ****************************************************************
    // register images
    // ****************************************************************
    logic [`FDCC_RATIO_W-1:0]     ratio_img_reg;
    logic [`FDCC_RATIO_W-1:0]     ratio_img_next;
    logic [`FDCC_PHASE_REG_W-1:0] phase_img_reg;
    logic [`FDCC_PHASE_REG_W-1:0] phase_img_next;
    logic [7:0]                   rdata_reg;
    logic [7:0]                   rdata_next;
    logic                         ratio_commit;
    logic                         phase_commit;
    logic                         adjust_request;
    logic                         adjust_busy;
    logic                         frac_lsb_violation;
    logic                         second_invalid;
    logic [`FDCC_GROUP_W-1:0]     group_active;
    logic [`FDCC_PH_W-1:0]        phase_active;
    logic [7:0]                   status_byte;

    // top ratio byte holds the fraction msbs and commits the group
    assign ratio_commit   = reg_wr && (reg_addr == `FDCC_ADDR_RATIO_LAST);
    assign phase_commit   = reg_wr && (reg_addr == `FDCC_ADDR_PHASE_HI);
    // write-one-to-start, only a 0 to 1 change counts
    assign adjust_request = phase_commit && reg_wdata[`FDCC_PH_ADJ_NOW_BIT-8]
                          && !adjust_busy;

    always_comb begin
        ratio_img_next = ratio_img_reg;
        phase_img_next = phase_img_reg;
        // byte lanes below the commit byte stage the group, second-stage ratio bits act at once
        if (reg_wr && (reg_addr <= `FDCC_ADDR_RATIO_LAST)) begin
            ratio_img_next[{reg_addr[2:0], 3'h0} +: 8] = reg_wdata;
        end
        if (reg_wr && (reg_addr == `FDCC_ADDR_PHASE_LO)) begin
            phase_img_next[7:0] = reg_wdata;
        end
        if (phase_commit) begin
            phase_img_next[15:8] = reg_wdata;
        end
        // immediate bit lives in the sequencer, reserved reads zero
        phase_img_next[`FDCC_PH_ADJ_NOW_BIT] = 1'b0;
        phase_img_next[`FDCC_PH_RSVD_BIT]    = 1'b0;
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ratio_img_reg <= `FDCC_RATIO_RESET;
            phase_img_reg <= `FDCC_PHASE_REG_RESET;
        end else begin
            ratio_img_reg <= ratio_img_next;
            phase_img_reg <= phase_img_next;
        end
    end

    // ****************************************************************
    // atomic groups
    // ****************************************************************
    fdcc_commit_reg #(
        .W         (`FDCC_GROUP_W),
        .RESET_VAL ({{`FDCC_FRAC_W{1'b0}}, `FDCC_FIRST_RESET})
    ) u_ratio_group (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .load    (ratio_commit),
        .d       ({ratio_img_next[`FDCC_FRAC_MSB:`FDCC_FRAC_LSB],
                   ratio_img_next[`FDCC_FIRST_MSB:0]}),
        .q       (group_active),
        .applied (ratio_apply)
    );

    fdcc_commit_reg #(
        .W         (`FDCC_PH_W),
        .RESET_VAL (`FDCC_PHASE_RESET)
    ) u_phase_group (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .load    (phase_commit),
        .d       (phase_img_next[`FDCC_PH_MSB:0]),
        .q       (phase_active),
        .applied ()
    );

    fdcc_phase_seq u_phase_seq (
        .clk_sys          (clk_sys),
        .resetn           (resetn),
        .adjust_request   (adjust_request),
        .post_sync_enable (phase_img_reg[`FDCC_PH_POST_SYNC_BIT]),
        .sync_event       (sync_event),
        .adjust_done      (phase_adjust_done),
        .busy             (adjust_busy),
        .apply            (phase_apply)
    );

    // ****************************************************************
    // divider controls
    // ****************************************************************
    assign divider_power_down  = ratio_img_reg[`FDCC_RATIO_PD_BIT];
    assign div_disable         = ratio_img_reg[`FDCC_RATIO_DIS_BIT];
    assign div_reset           = ratio_img_reg[`FDCC_RATIO_RST_BIT];
    assign acc_reset           = ratio_img_reg[`FDCC_RATIO_ACC_BIT];
    assign first_stage_integer = group_active[`FDCC_FIRST_W-1:0];
    // numerator over 2^FDCC_FRAC_DEN_LOG2
    assign frac_numerator      = group_active[`FDCC_GROUP_W-1:`FDCC_FIRST_W];
    assign second_stage_ratio  = {ratio_img_reg[`FDCC_SECOND_MSB:`FDCC_SECOND_LSB], 1'b0};
    assign second_stage_bypass = (ratio_img_reg[`FDCC_SECOND_MSB:`FDCC_SECOND_LSB] == '0);
    assign slow_freq_en        = phase_img_reg[`FDCC_PH_SLOW_BIT];
    assign sync_group0_member  = (phase_img_reg[`FDCC_PH_GROUP_MSB:`FDCC_PH_GROUP_LSB]
                                  == `FDCC_SYNC_GROUP0);
    assign sync_group1_member  = (phase_img_reg[`FDCC_PH_GROUP_MSB:`FDCC_PH_GROUP_LSB]
                                  == `FDCC_SYNC_GROUP1);
    // signed quarter vco periods, positive lags
    assign phase_offset        = $signed(phase_active);

    // ****************************************************************
    // status and read path
    // ****************************************************************
    assign frac_lsb_violation = spread_active
                              && (frac_numerator[`FDCC_SSC_ZERO_W-1:0] != '0);
    assign second_invalid     = (ratio_img_reg[`FDCC_SECOND_MSB:`FDCC_SECOND_LSB]
                                 == `FDCC_SECOND_W'(1));
    assign status_byte        = {5'h00, second_invalid, frac_lsb_violation, adjust_busy};

    always_comb begin
        rdata_next = 8'h00;
        if (reg_rd) begin
            if (reg_addr <= `FDCC_ADDR_RATIO_LAST) begin
                rdata_next = ratio_img_reg[{reg_addr[2:0], 3'h0} +: 8];
            end else if (reg_addr == `FDCC_ADDR_PHASE_LO) begin
                rdata_next = phase_img_reg[7:0];
            end else if (reg_addr == `FDCC_ADDR_PHASE_HI) begin
                rdata_next = {adjust_busy, phase_img_reg[14:8]};
            end else if (reg_addr == `FDCC_ADDR_STATUS) begin
                rdata_next = status_byte;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // ****************************************************************
    // checks
    // ****************************************************************
    ctrl_follow_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ratio_commit |=> (divider_power_down == $past(reg_wdata[7]))
                      && (div_disable == $past(reg_wdata[6])))
        else $error("power down or disable not taken");

    reset_follow_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ratio_commit |=> (div_reset == $past(reg_wdata[5]))
                      && (acc_reset == $past(reg_wdata[4])))
        else $error("divider or accumulator reset not taken");

    acc_indep_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ratio_commit && reg_wdata[4] && !reg_wdata[5]) |=> acc_reset && !div_reset)
        else $error("accumulator reset tied to divider reset");

    ratio_commit_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ratio_commit |=> ratio_apply
            && (frac_numerator[33:30] == $past(reg_wdata[3:0])))
        else $error("ratio group not applied on commit");

    ratio_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !ratio_commit |=> $stable(frac_numerator) && $stable(first_stage_integer)
                       && !ratio_apply)
        else $error("ratio group changed without commit");

    second_stage_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !second_stage_ratio[0] && (second_stage_bypass == (second_stage_ratio == '0)))
        else $error("second stage ratio malformed");

    sync_group_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (phase_commit && reg_wdata[3]) |=> !sync_group0_member && !sync_group1_member)
        else $error("divider in a group for codes 2 or 3");

    phase_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !phase_commit |=> $stable(phase_offset))
        else $error("phase changed without upper byte write");

    reset_vals_a: assert property (@(posedge clk_sys)
        !resetn |=> (phase_offset == -10'sd16) && (first_stage_integer == 9'h064)
                 && phase_img_reg[`FDCC_PH_POST_SYNC_BIT])
        else $error("reset values wrong");

    ratio_cover: cover property (@(posedge clk_sys) disable iff (!resetn)
        (reg_wr && reg_addr == 4'h6) ##[1:8] ratio_commit);

    spread_cover: cover property (@(posedge clk_sys) disable iff (!resetn)
        frac_lsb_violation);

endmodule

// ### tb/fdcc_top_bench.sv
// self-checking bench for the fractional divider configuration block
`timescale 1ns/1ps
`include "fdcc_regs.svh"

`define FB_CHK(what, exp, got) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("[FAIL] %s expected %0h seen %0h", what, exp, got); \
    end \
end

module fdcc_top_bench;

    // ****************************************************************
    // signals and design instance
    // ****************************************************************
    logic                          clk_sys;
    logic                          resetn;
    logic [`FDCC_ADDR_W-1:0]       reg_addr;
    logic [7:0]                    reg_wdata;
    logic                          reg_wr;
    logic                          reg_rd;
    logic [7:0]                    reg_rdata;
    logic                          spread_active;
    logic                          sync_event;
    logic                          phase_adjust_done;
    logic                          divider_power_down;
    logic                          div_disable;
    logic                          div_reset;
    logic                          acc_reset;
    logic [`FDCC_FIRST_W-1:0]      first_stage_integer;
    logic [`FDCC_FRAC_W-1:0]       frac_numerator;
    logic                          ratio_apply;
    logic [`FDCC_SECOND_W:0]       second_stage_ratio;
    logic                          second_stage_bypass;
    logic                          slow_freq_en;
    logic                          sync_group0_member;
    logic                          sync_group1_member;
    logic signed [`FDCC_PH_W-1:0]  phase_offset;
    logic                          phase_apply;
    int                            bad_count;
    int                            total_checks;
    logic [63:0]                   ratio_val;

    fdcc_top i_fdcc_top (
        .clk_sys             (clk_sys),
        .resetn              (resetn),
        .reg_addr            (reg_addr),
        .reg_wdata           (reg_wdata),
        .reg_wr              (reg_wr),
        .reg_rd              (reg_rd),
        .reg_rdata           (reg_rdata),
        .spread_active       (spread_active),
        .sync_event          (sync_event),
        .phase_adjust_done   (phase_adjust_done),
        .divider_power_down  (divider_power_down),
        .div_disable         (div_disable),
        .div_reset           (div_reset),
        .acc_reset           (acc_reset),
        .first_stage_integer (first_stage_integer),
        .frac_numerator      (frac_numerator),
        .ratio_apply         (ratio_apply),
        .second_stage_ratio  (second_stage_ratio),
        .second_stage_bypass (second_stage_bypass),
        .slow_freq_en        (slow_freq_en),
        .sync_group0_member  (sync_group0_member),
        .sync_group1_member  (sync_group1_member),
        .phase_offset        (phase_offset),
        .phase_apply         (phase_apply)
    );

    // ****************************************************************
    // bus and pulse helpers
    // ****************************************************************
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
        #1;
    endtask

    task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1'h1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1;
        d = reg_rdata;
    endtask

    task automatic sync_pulse(input logic exp);
        @(posedge clk_sys);
        sync_event <= 1'h1;
        #1;
        `FB_CHK("post-sync apply", exp, phase_apply)
        @(posedge clk_sys);
        sync_event <= 1'h0;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic check_reset_state();
        logic [7:0]  d;
        logic [63:0] rv;
        rv = `FDCC_RATIO_RESET;
        `FB_CHK("first stage", 9'h064, first_stage_integer)
        `FB_CHK("fraction", 34'h0, frac_numerator)
        `FB_CHK("phase", 10'h3F0, phase_offset)
        `FB_CHK("controls", 4'h0, {divider_power_down, div_disable, div_reset, acc_reset})
        `FB_CHK("bypass", 1'h1, second_stage_bypass)
        `FB_CHK("group0", 2'h1, {sync_group1_member, sync_group0_member})
        for (int k = 0; k < 8; k++) begin
            bus_rd(k[3:0], d);
            `FB_CHK("ratio byte", rv[8*k+:8], d)
        end
        bus_rd(4'h8, d);
        `FB_CHK("phase lo", 8'hF0, d)
        bus_rd(4'h9, d);
        `FB_CHK("phase hi", 8'h43, d)
        bus_rd(4'hB, d);
        `FB_CHK("unmapped", 8'h00, d)
        @(posedge clk_sys);
        #1;
        `FB_CHK("rdata idle", 8'h00, reg_rdata)
    endtask

    task automatic ratio_commit();
        logic [7:0] d;
        ratio_val = {4'h0, 34'h2_3456_789A, 17'h0_0003, 9'h1C5};
        for (int k = 0; k < 7; k++) begin
            bus_wr(k[3:0], ratio_val[8*k+:8]);
        end
        `FB_CHK("first staged", 9'h064, first_stage_integer)
        `FB_CHK("frac staged", 34'h0, frac_numerator)
        `FB_CHK("second ratio", 18'h0_0006, second_stage_ratio)
        `FB_CHK("bypass off", 1'h0, second_stage_bypass)
        bus_wr(4'h7, ratio_val[63:56]);
        `FB_CHK("apply pulse", 1'h1, ratio_apply)
        `FB_CHK("first new", 9'h1C5, first_stage_integer)
        `FB_CHK("frac new", 34'h2_3456_789A, frac_numerator)
        @(posedge clk_sys);
        #1;
        `FB_CHK("apply end", 1'h0, ratio_apply)
        bus_rd(4'h3, d);
        `FB_CHK("readback", ratio_val[31:24], d)
    endtask

    task automatic control_bits();
        logic [3:0] seq [5];
        // divider reset rides with power-down, then with disable, then alone, and is released in the same write that sets accumulator reset
        seq = '{4'hA, 4'h6, 4'h2, 4'h1, 4'h0};
        for (int i = 0; i < 5; i++) begin
            bus_wr(4'h7, {seq[i], ratio_val[59:56]});
            `FB_CHK("controls", seq[i],
                {divider_power_down, div_disable, div_reset, acc_reset})
            `FB_CHK("frac kept", 34'h2_3456_789A, frac_numerator)
        end
    endtask

    task automatic spread_check();
        logic [7:0] d;
        bus_rd(4'hA, d);
        `FB_CHK("lsb flag idle", 8'h00, d)
        bus_wr(4'h3, {6'h00, ratio_val[25:24]});
        bus_wr(4'h7, ratio_val[63:56]);
        `FB_CHK("frac lsb zero", 34'h2_3456_7880, frac_numerator)
        @(posedge clk_sys);
        spread_active <= 1'h1;
        bus_rd(4'hA, d);
        `FB_CHK("lsb flag spread", 8'h00, d)
    endtask

    task automatic phase_config();
        logic [7:0] d;
        bus_wr(4'h8, 8'h25);
        `FB_CHK("phase staged", 10'h3F0, phase_offset)
        for (int g = 0; g < 4; g++) begin
            bus_wr(4'h9, {4'h3, g[1:0], 2'h1});
            `FB_CHK("phase new", 10'h125, phase_offset)
            `FB_CHK("slow", 1'h1, slow_freq_en)
            `FB_CHK("members", {g == 1, g == 0}, {sync_group1_member, sync_group0_member})
        end
        bus_rd(4'h9, d);
        `FB_CHK("phase hi rb", 8'h2D, d)
        sync_pulse(1'h0);
    endtask

    task automatic phase_immediate();
        logic [7:0] d;
        bus_wr(4'h9, 8'hC3);
        `FB_CHK("adjust apply", 1'h1, phase_apply)
        `FB_CHK("phase neg", 10'h325, phase_offset)
        @(posedge clk_sys);
        #1;
        `FB_CHK("apply end", 1'h0, phase_apply)
        bus_rd(4'h9, d);
        `FB_CHK("busy bit", 1'h1, d[7])
        bus_wr(4'h9, 8'hC3);
        `FB_CHK("no restart", 1'h0, phase_apply)
        bus_rd(4'hA, d);
        `FB_CHK("status", 8'h01, d)
        @(posedge clk_sys);
        phase_adjust_done <= 1'h1;
        @(posedge clk_sys);
        phase_adjust_done <= 1'h0;
        bus_rd(4'h9, d);
        `FB_CHK("self clear", 8'h43, d)
        sync_pulse(1'h1);
    endtask

    // ****************************************************************
    // clock, reset, sequence and verdict
    // ****************************************************************
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (100000) @(posedge clk_sys);
        bad_count++;
        end_of_test();
    end

    initial begin
        bad_count         = 0;
        total_checks      = 0;
        resetn            = 1'h0;
        reg_addr          = 4'h0;
        reg_wdata         = 8'h00;
        reg_wr            = 1'h0;
        reg_rd            = 1'h0;
        spread_active     = 1'h0;
        sync_event        = 1'h0;
        phase_adjust_done = 1'h0;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'h1;
        #1;
        check_reset_state();
        ratio_commit();
        control_bits();
        spread_check();
        phase_config();
        phase_immediate();
        end_of_test();
    end

endmodule
